/* include/ddsc_pkg.sv */
package ddsc_pkg;
  // Word geometry
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int CNT_BITS = 5;
  // Bit positions inside the received word, first bit in at the top
  localparam int POS_SPARE_FIRST = 15;
  localparam int POS_SPARE_SECOND = 14;
  localparam int POS_SPARE_THIRD = 13;
  localparam int POS_SHUTDOWN_B = 12;
  localparam int POS_SHUTDOWN_A = 11;
  localparam int POS_SPARE_FOURTH = 10;
  localparam int POS_LOAD_B = 9;
  localparam int POS_LOAD_A = 8;
  localparam int POS_CODE_MSB = 7;
  localparam int POS_CODE_LSB = 0;
  // Reset values
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic SHUTDOWN_RST = 1'b1;
  // Host timing: the link clock is the system clock divided by 2*HALF_DIV
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_MAX_MHZ = 25;
  localparam int HALF_DIV = (SYS_CLK_MHZ + 2 * LINK_MAX_MHZ - 1) / (2 * LINK_MAX_MHZ);
  localparam int SEL_SETUP_NS = 50;
  localparam int SEL_SETUP_CYC = (SEL_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SEL_HIGH_NS = 50;
  localparam int SEL_HIGH_CYC = (SEL_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] TIMER_ONE = 8'h01;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_WORD = 5'h10;
endpackage

/* include/ddsc_if.sv */
`timescale 1ns/1ns
interface ddsc_if;
  logic sel_n;
  logic sclk;
  logic sdata;
  modport host (output sel_n, output sclk, output sdata);
  modport device (input sel_n, input sclk, input sdata);
endinterface

/* core/ddsc_shift.sv */
`timescale 1ns/1ns
module ddsc_shift (
  // Link clock and framing
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_sdata,
  // Captured word
  output logic [15:0] o_word
);
  // Shift only inside a frame; sclk edges with select high leave it alone
  always_ff @(posedge i_sclk) begin
    if (!i_sel_n) begin
      o_word <= {o_word[ddsc_pkg::WORD_BITS-2:0], i_sdata};
    end
  end
endmodule // ddsc_shift

/* core/ddsc_device.sv */
`timescale 1ns/1ns
// How it works
// - Low select frames a write, shifting enabled
// - Data sampled on rising serial clock
// - Serial clock up to 25 MHz
// - Sixteen bits, first bit lands on top
// - Clock gaps allowed while select low
// - Select rising edge executes held word
// - Host sends all 16 bits first
// - Single register per channel, no holding stage
// - Spares, shutdowns, spare, loads, then data
// - Control bits act independently, never decoded
// - Load bits write data into channel
// - Either shutdown bit set means shutdown
// - Spare bits are ignored
// - Shutdown forces both outputs to zero
// - Shutdown keeps stored codes intact
// - Leaving shutdown restores stored codes
// - Each register drives its unsigned code
// - No load bit leaves registers unchanged
// - Reset clears registers, outputs zero
// - Host uses idle-low clock, phase zero
module ddsc_device (
  // Reset
  input wire logic I_RESET_N,
  // Link
  ddsc_if.device LINK,
  // Converter codes
  output logic [7:0] O_ANALOG_OUT_FIRST,
  output logic [7:0] O_ANALOG_OUT_SECOND,
  output logic O_SHUTDOWN
);
  logic [15:0] word;
  logic [7:0] code_a_r;
  logic [7:0] code_b_r;
  logic shutdown_r;
  logic load_chan_a;
  logic load_chan_b;
  logic shutdown_bit_a;
  logic shutdown_bit_b;
  logic [7:0] code_nxt;

  ddsc_shift u_shift (
    .i_sclk(LINK.sclk),
    .i_sel_n(LINK.sel_n),
    .i_sdata(LINK.sdata),
    .o_word(word)
  );

  // Field split; spare bits are never read
  assign load_chan_a = word[ddsc_pkg::POS_LOAD_A];
  assign load_chan_b = word[ddsc_pkg::POS_LOAD_B];
  assign shutdown_bit_a = word[ddsc_pkg::POS_SHUTDOWN_A];
  assign shutdown_bit_b = word[ddsc_pkg::POS_SHUTDOWN_B];
  assign code_nxt = word[ddsc_pkg::POS_CODE_MSB:ddsc_pkg::POS_CODE_LSB];

  // Execute on select rise; the select pin itself is the clock, as in the part,
  // so there is no free-running clock to sample with
  always_ff @(posedge LINK.sel_n or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      code_a_r <= ddsc_pkg::CODE_RST;
    end else if (load_chan_a) begin
      code_a_r <= code_nxt;
    end
  end

  always_ff @(posedge LINK.sel_n or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      code_b_r <= ddsc_pkg::CODE_RST;
    end else if (load_chan_b) begin
      code_b_r <= code_nxt;
    end
  end

  // Shutdown state; reset behaves as shutdown
  always_ff @(posedge LINK.sel_n or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      shutdown_r <= ddsc_pkg::SHUTDOWN_RST;
    end else begin
      shutdown_r <= shutdown_bit_a | shutdown_bit_b;
    end
  end

  // Outputs forced low in shutdown while codes are kept
  assign O_ANALOG_OUT_FIRST = shutdown_r ? ddsc_pkg::CODE_RST : code_a_r;
  assign O_ANALOG_OUT_SECOND = shutdown_r ? ddsc_pkg::CODE_RST : code_b_r;
  assign O_SHUTDOWN = shutdown_r;
endmodule // ddsc_device

/* core/ddsc_host.sv */
`timescale 1ns/1ns
module ddsc_host (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Write request
  input wire logic I_VALID,
  input wire logic [15:0] I_WORD,
  output logic O_READY,
  // Link
  ddsc_if.host LINK
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_GAP = 4'b1000
  } ddsc_state_t;

  ddsc_state_t state_r;
  logic [15:0] word_r;
  logic [7:0] timer_r;
  logic [4:0] cnt_r;
  logic sclk_r;
  logic sel_n_r;

  assign O_READY = (state_r == ST_IDLE);
  assign LINK.sel_n = sel_n_r;
  assign LINK.sclk = sclk_r; // idle low
  assign LINK.sdata = word_r[ddsc_pkg::WORD_BITS-1]; // MSB first

  // Frame sequencer; the divider keeps the link clock at or under its limit
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= ST_IDLE;
      word_r <= ddsc_pkg::WORD_RST;
      timer_r <= '0;
      cnt_r <= '0;
      sclk_r <= 1'b0;
      sel_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (I_VALID) begin
            word_r <= I_WORD; // layout carried by caller
            sel_n_r <= 1'b0;
            timer_r <= 8'(ddsc_pkg::SEL_SETUP_CYC);
            cnt_r <= '0;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_r == ddsc_pkg::TIMER_ONE) begin
            timer_r <= 8'(ddsc_pkg::HALF_DIV);
            sclk_r <= 1'b1; // data already stable
            state_r <= ST_SHIFT;
          end else begin
            timer_r <= timer_r - ddsc_pkg::TIMER_ONE;
          end
        end
        ST_SHIFT: begin
          if (timer_r == ddsc_pkg::TIMER_ONE) begin
            timer_r <= 8'(ddsc_pkg::HALF_DIV);
            if (sclk_r) begin
              sclk_r <= 1'b0; // data changes on falling edge
              word_r <= {word_r[ddsc_pkg::WORD_BITS-2:0], 1'b0};
              cnt_r <= cnt_r + ddsc_pkg::CNT_ONE;
              if (cnt_r == ddsc_pkg::CNT_WORD - ddsc_pkg::CNT_ONE) begin
                timer_r <= 8'(ddsc_pkg::SEL_SETUP_CYC);
                state_r <= ST_GAP;
              end
            end else begin
              sclk_r <= 1'b1;
            end
          end else begin
            timer_r <= timer_r - ddsc_pkg::TIMER_ONE;
          end
        end
        ST_GAP: begin
          // Hold after last edge, then raise select and keep it high a while
          if (timer_r == ddsc_pkg::TIMER_ONE) begin
            if (sel_n_r) begin
              state_r <= ST_IDLE;
            end else begin
              sel_n_r <= 1'b1; // execute
              timer_r <= 8'(ddsc_pkg::SEL_HIGH_CYC);
            end
          end else begin
            timer_r <= timer_r - ddsc_pkg::TIMER_ONE;
          end
        end
      endcase
    end
  end
endmodule // ddsc_host

/* testbench/ddsc_link_props.sv */
`timescale 1ns/1ns
module ddsc_link_props (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Link
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdata
);
  logic sclk_d_r;
  logic [4:0] rises_r;
  // Count link rises per frame; the host clock oversamples the link
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sclk_d_r <= 1'b0;
      rises_r <= 5'h00;
    end else begin
      sclk_d_r <= sclk;
      if (sel_n) rises_r <= 5'h00;
      else if (sclk && !sclk_d_r) rises_r <= rises_r + 5'h01;
    end
  end
  // Single domain, so one default clock and disable
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  AST_IDLE_LOW: assert property (sel_n |-> !sclk)
    else $error("link clock high outside frame");
  AST_HALF_HIGH: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("link clock high phase wrong");
  AST_HALF_LOW: assert property ($fell(sclk) |=> !sclk)
    else $error("link clock low phase too short");
  AST_SETUP: assert property ($fell(sel_n) |-> !sclk [*5])
    else $error("select to first edge too short");
  AST_COUNT: assert property ($rose(sel_n) |-> rises_r == 5'h10)
    else $error("frame not sixteen bits");
  AST_SEL_HIGH: assert property ($rose(sel_n) |-> sel_n [*5])
    else $error("select high pulse too short");
  AST_FRAME: assert property ($fell(sel_n) |-> ##[64:200] $rose(sel_n))
    else $error("frame length out of range");
  AST_DATA_EDGE: assert property ($changed(sdata) |-> !sclk)
    else $error("data moved while clock high");
  AST_DATA_STABLE: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data moved at sampling edge");
  // Main scenarios reached
  cover property ($rose(sel_n));
  cover property ($rose(sel_n) ##[5:30] $fell(sel_n));
  cover property ($rose(sclk) && sdata);
endmodule // ddsc_link_props

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic reset_n;
  logic valid;
  logic [15:0] word;
  logic ready;
  logic [7:0] out_a;
  logic [7:0] out_b;
  logic shutdown;
  int miscompares = 0;
  int checks = 0;
  ddsc_if link ();
  ddsc_host i_ddsc_host (.I_CLK(clk), .I_RESET_N(reset_n), .I_VALID(valid), .I_WORD(word),
    .O_READY(ready), .LINK(link.host));
  ddsc_device i_ddsc_device (.I_RESET_N(reset_n), .LINK(link.device), .O_ANALOG_OUT_FIRST(out_a),
    .O_ANALOG_OUT_SECOND(out_b), .O_SHUTDOWN(shutdown));
  ddsc_link_props i_ddsc_link_props (.I_CLK(clk), .I_RESET_N(reset_n), .sel_n(link.sel_n),
    .sclk(link.sclk), .sdata(link.sdata));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Expected {shutdown, a, b}
  task automatic chk(input string nm, input logic [16:0] e);
    checks++;
    if ({shutdown, out_a, out_b} !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, {shutdown, out_a, out_b});
    end
  endtask
  // One write; waits until the host is idle again, bounded
  task automatic send(input logic [15:0] w);
    int n;
    @(posedge clk); #1;
    valid = 1'b1;
    word = w;
    @(posedge clk); #1;
    valid = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge clk); #1;
      n++;
    end
    if (n >= 300) miscompares++;
  endtask
  task automatic t_load;
    chk("reset", 17'h10000);
    send(16'h2380); chk("both", 17'h08080);
    send(16'he53c); chk("a spares", 17'h03c80);
    send(16'h025a); chk("b only", 17'h03c5a);
    send(16'h00ff); chk("no load", 17'h03c5a);
    $display("test load done");
  endtask
  task automatic t_shut;
    send(16'h0911); chk("shut a", 17'h10000);
    send(16'h0000); chk("wake", 17'h0115a);
    send(16'h1000); chk("shut b", 17'h10000);
    send(16'h1b77); chk("shut both load", 17'h10000);
    send(16'h0000); chk("keep", 17'h07777);
    $display("test shutdown done");
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog, far above the nine frames expected
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    valid = 1'b0;
    word = 16'h0000;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    @(posedge clk); #1;
    t_load();
    t_shut();
    end_of_test();
  end
endmodule // testbench
